// >>> rtl/pac_conditioning.sv
// Purpose: position actual value conditioning, four indexed channels
// Assumes: encoder inputs synchronous to hclk, one update per clock
// Notes:   channel 0 mirrors the encoder channel used by position control
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

module pac_conditioning (
  // clock and reset
  input  logic                          hclk,
  input  logic                          hresetn,
  // ahb-lite slave
  input  logic                          hsel,
  input  logic [31:0]                   haddr,
  input  logic [1:0]                    htrans,
  input  logic                          hwrite,
  input  logic [2:0]                    hsize,
  input  logic [31:0]                   hwdata,
  input  logic                          hready,
  output logic                          hreadyout,
  output logic [1:0]                    hresp,
  output logic [31:0]                   hrdata,
  // encoder evaluations
  input  pac_pkg::pac_enc_in_t [2:0]    enc_in,
  output logic [2:0][15:0]              encoder_control_out,
  // per channel connector inputs
  input  pac_pkg::pac_ch_in_t [3:0]     ch_in,
  input  logic                          basic_positioner_active,
  // per channel results
  output logic [3:0][31:0]              position_actual_out,
  output logic [3:0][31:0]              velocity_actual_out,
  output logic [3:0][31:0]              probe_measured_value,
  output logic [3:0]                    reference_point_connect
);

  pac_pkg::pac_state_t st_q;
  pac_pkg::pac_state_t st_d;

  // ----------------------------------------------------------------
  // scaling arithmetic
  // ----------------------------------------------------------------
  // increments times numerator over denominator, kept to 32 bits
  function automatic logic signed [31:0] pac_scale(input logic signed [31:0] inc,
                                                   input logic signed [63:0] num,
                                                   input logic signed [63:0] den);
    logic signed [95:0] prod;
    logic signed [95:0] quo;
    prod = 96'(inc) * 96'(num);
    if (den == 64'sh0)
    begin
      quo = '0;
    end
    else
    begin
      quo = prod / 96'(den);
    end
    return signed'(quo[31:0]);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        [31:0] rd;
    logic        [7:0]  wa;
    logic        [1:0]  wi;
    logic        [63:0] res;
    logic        [7:0]  gear;
    logic signed [63:0] num;
    logic signed [63:0] den;
    logic signed [31:0] scaled;
    logic signed [31:0] cap_scaled;
    logic signed [31:0] corr;
    logic signed [31:0] offs;
    logic signed [31:0] setv;
    logic signed [31:0] adjv;
    logic signed [31:0] p;
    logic               sel0;
    logic               hold;
    logic               adj;
    logic               pen;
    logic        [15:0] cw;
    int unsigned        c;
    rd = '0;
    wa = st_q.a_addr;
    wi = st_q.a_addr[3:2];
    res = '0;
    gear = '0;
    num = '0;
    den = '0;
    scaled = '0;
    cap_scaled = '0;
    corr = '0;
    offs = '0;
    setv = '0;
    adjv = '0;
    p = '0;
    sel0 = 1'b0;
    hold = 1'b0;
    adj = 1'b0;
    pen = 1'b0;
    cw = '0;
    c = 0;
    st_d = st_q;

    // address phase: capture write target, fetch read data
    st_d.a_wr = 1'b0;
    if (hsel && hready && (htrans == pac_pkg::HTRANS_NONSEQ))
    begin
      st_d.a_wr = hwrite;
      st_d.a_addr = haddr[7:0];
      st_d.a_map = (haddr[31:8] == 24'h00_0000);
      if (!hwrite)
      begin
        if (haddr[31:8] != 24'h00_0000)
        begin
          rd = '0;
        end
        else if (haddr[7:0] == pac_pkg::OFF_CONFIG)
        begin
          rd[pac_pkg::CFG_ASSIGN_LSB +: 2] = st_q.assign_sel;
          rd[pac_pkg::CFG_LINEAR_BIT] = st_q.linear;
        end
        else if (haddr[7:0] == pac_pkg::OFF_UNITS_REV)
          rd = st_q.units_rev;
        else if (haddr[7:0] == pac_pkg::OFF_MOTOR_REVS)
          rd = st_q.motor_revs;
        else if (haddr[7:0] == pac_pkg::OFF_LOAD_REVS)
          rd = st_q.load_revs;
        else if (haddr[7:0] == pac_pkg::OFF_LIN_10MM)
          rd = st_q.lin_10mm;
        else if (haddr[7:0] == pac_pkg::OFF_STATUS)
          rd = {29'h0000_0000, st_q.seen};
        else if (pac_pkg::pac_hit(haddr[7:0], pac_pkg::OFF_ENC_CFG, pac_pkg::NUM_ENC))
          rd = st_q.enc_cfg[haddr[3:2]];
        else if (pac_pkg::pac_hit(haddr[7:0], pac_pkg::OFF_PROBE_CFG, pac_pkg::NUM_CH))
          rd = {28'h000_0000, st_q.probe_cfg[haddr[3:2]]};
        else if (pac_pkg::pac_hit(haddr[7:0], pac_pkg::OFF_ADJ_CTRL, pac_pkg::NUM_CH))
        begin
          rd[pac_pkg::ADJ_START_BIT] = st_q.adj_start[haddr[3:2]];
          rd[pac_pkg::ADJ_DONE_BIT] = st_q.adj_done[haddr[3:2]];
        end
        else if (pac_pkg::pac_hit(haddr[7:0], pac_pkg::OFF_ADJ_OFFSET, pac_pkg::NUM_CH))
          rd = st_q.adj_off[haddr[3:2]];
        else if (pac_pkg::pac_hit(haddr[7:0], pac_pkg::OFF_POSITION, pac_pkg::NUM_CH))
          rd = st_q.pos[haddr[3:2]];
        else if (pac_pkg::pac_hit(haddr[7:0], pac_pkg::OFF_VELOCITY, pac_pkg::NUM_CH))
          rd = st_q.vel[haddr[3:2]];
        else if (pac_pkg::pac_hit(haddr[7:0], pac_pkg::OFF_MEASURED, pac_pkg::NUM_CH))
          rd = st_q.meas[haddr[3:2]];
        st_d.rdata = rd;
      end
    end

    // data phase: store write data; unmapped addresses are ignored
    if (st_q.a_wr && st_q.a_map)
    begin
      if (wa == pac_pkg::OFF_CONFIG)
      begin
        st_d.assign_sel = hwdata[pac_pkg::CFG_ASSIGN_LSB +: 2];
        st_d.linear = hwdata[pac_pkg::CFG_LINEAR_BIT];
      end
      else if (wa == pac_pkg::OFF_UNITS_REV)
        st_d.units_rev = hwdata;
      else if (wa == pac_pkg::OFF_MOTOR_REVS)
        st_d.motor_revs = hwdata;
      else if (wa == pac_pkg::OFF_LOAD_REVS)
        st_d.load_revs = hwdata;
      else if (wa == pac_pkg::OFF_LIN_10MM)
        st_d.lin_10mm = hwdata;
      else if (pac_pkg::pac_hit(wa, pac_pkg::OFF_ENC_CFG, pac_pkg::NUM_ENC))
        st_d.enc_cfg[wi] = hwdata;
      else if (pac_pkg::pac_hit(wa, pac_pkg::OFF_PROBE_CFG, pac_pkg::NUM_CH))
        st_d.probe_cfg[wi] = hwdata[3:0];
      else if (pac_pkg::pac_hit(wa, pac_pkg::OFF_ADJ_CTRL, pac_pkg::NUM_CH))
      begin
        if (hwdata[pac_pkg::ADJ_START_BIT])
        begin
          st_d.adj_start[wi] = 1'b1;
          st_d.adj_done[wi] = 1'b0;
        end
      end
      else if (pac_pkg::pac_hit(wa, pac_pkg::OFF_ADJ_OFFSET, pac_pkg::NUM_CH))
        st_d.adj_off[wi] = hwdata;
    end

    // one datapath per encoder, all three run side by side
    for (int e = 0; e < pac_pkg::NUM_ENC; e++)
    begin
      c = 32'(e) + 1;
      sel0 = (st_q.assign_sel == 2'(c));
      // resolution and scale factors
      gear = st_q.enc_cfg[e][pac_pkg::ENC_GEAR_LSB +: 8];
      res = 64'(st_q.enc_cfg[e][pac_pkg::ENC_PULSES_LSB +: 16])
            << st_q.enc_cfg[e][pac_pkg::ENC_FINE_LSB +: 5];
      res = res * ((gear == 8'h00) ? 64'h1 : 64'(gear));
      if (st_q.linear)
      begin
        num = signed'({32'h0000_0000, st_q.lin_10mm});
        den = signed'(res);
      end
      else
      begin
        num = signed'({32'h0000_0000, st_q.units_rev})
              * 64'(signed'(st_q.load_revs));
        den = signed'(res) * 64'(signed'(st_q.motor_revs));
      end
      // connector inputs of this channel plus channel 0 when assigned
      hold = ch_in[c].set_req || (sel0 && ch_in[0].set_req);
      setv = ch_in[c].set_req ? signed'(ch_in[c].set_val) : signed'(ch_in[0].set_val);
      corr = '0;
      if (ch_in[c].corr_act && !st_q.corr_prev[c])
        corr = corr + signed'(ch_in[c].corr_val);
      if (sel0 && ch_in[0].corr_act && !st_q.corr_prev[0])
        corr = corr + signed'(ch_in[0].corr_val);
      offs = signed'(ch_in[c].offset) + (sel0 ? signed'(ch_in[0].offset) : 32'sh0);
      adj = st_q.adj_start[c] || (sel0 && st_q.adj_start[0]);
      adjv = st_q.adj_start[c] ? signed'(st_q.adj_off[c]) : signed'(st_q.adj_off[0]);
      // increments counted only once valid, dropped while held
      if (enc_in[e].valid)
      begin
        st_d.seen[e] = 1'b1;
        st_d.prev_raw[e] = enc_in[e].raw;
        if (st_q.seen[e] && !hold)
          st_d.inc_acc[e] = st_q.inc_acc[e] + (enc_in[e].raw - st_q.prev_raw[e]);
      end
      scaled = pac_scale(signed'(st_d.inc_acc[e]), num, den);
      cap_scaled = pac_scale(signed'(st_d.inc_acc[e] + (enc_in[e].captured - enc_in[e].raw)),
                             num, den);
      if (st_q.enc_cfg[e][pac_pkg::ENC_INVERT_BIT])
      begin
        scaled = -scaled;
        cap_scaled = -cap_scaled;
      end
      // base absorbs set value, adjustment and corrections
      if (hold)
      begin
        st_d.base[e] = setv - offs - scaled;
        p = setv;
      end
      else
      begin
        if (adj)
          st_d.base[e] = adjv - offs - scaled;
        else
          st_d.base[e] = st_q.base[e] + corr;
        p = signed'(st_d.base[e]) + scaled + offs;
      end
      st_d.pos[c] = p;
      st_d.vel[c] = p - signed'(st_q.pos[c]);
      // adjustment done: hardware set wins over software restart clear
      if (st_q.adj_start[c])
      begin
        st_d.adj_start[c] = 1'b0;
        st_d.adj_done[c] = 1'b1;
      end
      // probe on non-control channels only; request goes out in control word
      pen = st_q.probe_cfg[c][pac_pkg::PROBE_EN_BIT] && !sel0;
      cw = '0;
      if (pen)
      begin
        cw[pac_pkg::CW_PROBE_RISE_BIT] = !st_q.probe_cfg[c][pac_pkg::PROBE_EDGE_BIT];
        cw[pac_pkg::CW_PROBE_FALL_BIT] = st_q.probe_cfg[c][pac_pkg::PROBE_EDGE_BIT];
        cw[pac_pkg::CW_PROBE_SRC_LSB +: 2] = st_q.probe_cfg[c][pac_pkg::PROBE_SRC_LSB +: 2];
      end
      st_d.ctrl_out[e] = cw;
      if (pen && enc_in[e].valid && enc_in[e].status[pac_pkg::STS_MEAS_VALID])
        st_d.meas[c] = signed'(st_d.base[e]) + cap_scaled + offs;
    end

    // channel 0 mirrors the assigned encoder channel
    if (st_d.assign_sel != 2'h0)
    begin
      st_d.pos[0] = st_d.pos[st_d.assign_sel];
      st_d.vel[0] = st_d.vel[st_d.assign_sel];
    end
    else
    begin
      st_d.pos[0] = '0;
      st_d.vel[0] = '0;
    end
    if (st_q.adj_start[0] && (st_q.assign_sel != 2'h0))
    begin
      st_d.adj_start[0] = 1'b0;
      st_d.adj_done[0] = 1'b1;
    end
    for (int k = 0; k < pac_pkg::NUM_CH; k++)
      st_d.corr_prev[k] = ch_in[k].corr_act;
    st_d.ref_conn = {3'h0, basic_positioner_active};
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= '0;
      st_q.assign_sel <= pac_pkg::RST_ASSIGN;
      st_q.units_rev <= pac_pkg::RST_UNITS_REV;
      st_q.motor_revs <= pac_pkg::RST_MOTOR_REVS;
      st_q.load_revs <= pac_pkg::RST_LOAD_REVS;
      st_q.lin_10mm <= pac_pkg::RST_LIN_10MM;
      st_q.enc_cfg <= {pac_pkg::NUM_ENC{pac_pkg::RST_ENC_CFG}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // outputs
  assign hreadyout = 1'b1;
  assign hresp = pac_pkg::HRESP_OKAY;
  assign hrdata = st_q.rdata;
  assign encoder_control_out = st_q.ctrl_out;
  assign position_actual_out = st_q.pos;
  assign velocity_actual_out = st_q.vel;
  assign probe_measured_value = st_q.meas;
  assign reference_point_connect = st_q.ref_conn;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ch0_mirror;
    (st_q.assign_sel != 2'h0) |-> position_actual_out[0] == position_actual_out[st_q.assign_sel];
  endproperty
  a_ch0_mirror: assert property (p_ch0_mirror)
    else $error("channel 0 differs from assigned channel");

  property p_hold;
    ch_in[1].set_req |=> position_actual_out[1] == $past(ch_in[1].set_val);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held position not equal to setting value");

  property p_corr;
    (ch_in[1].corr_act && !st_q.corr_prev[1] && !ch_in[1].set_req && !st_q.adj_start[1]
     && (st_q.assign_sel != 2'h1) && st_q.seen[0] && enc_in[0].valid
     && (enc_in[0].raw == st_q.prev_raw[0]) && $stable(ch_in[1].offset))
    |=> position_actual_out[1] == $past(position_actual_out[1]) + $past(ch_in[1].corr_val);
  endproperty
  a_corr: assert property (p_corr)
    else $error("correction not applied on rising edge");

  property p_vel;
    ##1 velocity_actual_out[1] == position_actual_out[1] - $past(position_actual_out[1]);
  endproperty
  a_vel: assert property (p_vel)
    else $error("velocity not equal to position change");

  property p_adj;
    $rose(st_q.adj_start[3]) |-> ##1 (st_q.adj_done[3] && !st_q.adj_start[3]);
  endproperty
  a_adj: assert property (p_adj)
    else $error("adjustment done not reported");

  property p_probe_gate;
    (st_q.assign_sel == 2'h2) |=> encoder_control_out[1] == 16'h0000;
  endproperty
  a_probe_gate: assert property (p_probe_gate)
    else $error("probe requested on position control encoder");

  property p_meas;
    !(enc_in[2].valid && enc_in[2].status[pac_pkg::STS_MEAS_VALID])
    |=> $stable(probe_measured_value[3]);
  endproperty
  a_meas: assert property (p_meas)
    else $error("measured value changed without valid bit");

  property p_ref;
    ##1 reference_point_connect == {3'h0, $past(basic_positioner_active)};
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference source connection wrong");

  property p_no_valid;
    !enc_in[2].valid |=> $stable(st_q.inc_acc[2]);
  endproperty
  a_no_valid: assert property (p_no_valid)
    else $error("increments counted without valid encoder");

endmodule // pac_conditioning

// >>> rtl/pac_pkg.sv
// Purpose: shared constants, carriers and state layout for position conditioning
// Assumes: 32-bit AHB-Lite register bus, three encoder evaluations, four channels
// Notes:   register byte offsets below are the software map of the block
package pac_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_ENC = 3;
  localparam int unsigned NUM_CH  = 4;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CONFIG     = 8'h00;
  localparam logic [7:0] OFF_UNITS_REV  = 8'h04;
  localparam logic [7:0] OFF_MOTOR_REVS = 8'h08;
  localparam logic [7:0] OFF_LOAD_REVS  = 8'h0C;
  localparam logic [7:0] OFF_LIN_10MM   = 8'h10;
  localparam logic [7:0] OFF_STATUS     = 8'h14;
  localparam logic [7:0] OFF_ENC_CFG    = 8'h20; // one word per encoder
  localparam logic [7:0] OFF_PROBE_CFG  = 8'h30; // one word per channel
  localparam logic [7:0] OFF_ADJ_CTRL   = 8'h40;
  localparam logic [7:0] OFF_ADJ_OFFSET = 8'h50;
  localparam logic [7:0] OFF_POSITION   = 8'h60;
  localparam logic [7:0] OFF_VELOCITY   = 8'h70;
  localparam logic [7:0] OFF_MEASURED   = 8'h80;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_ASSIGN_LSB    = 0;
  localparam int unsigned CFG_LINEAR_BIT    = 2;
  localparam int unsigned ENC_PULSES_LSB    = 0;
  localparam int unsigned ENC_FINE_LSB      = 16;
  localparam int unsigned ENC_INVERT_BIT    = 21;
  localparam int unsigned ENC_GEAR_LSB      = 24;
  localparam int unsigned PROBE_EN_BIT      = 0;
  localparam int unsigned PROBE_SRC_LSB     = 1;
  localparam int unsigned PROBE_EDGE_BIT    = 3;
  localparam int unsigned ADJ_START_BIT     = 2;
  localparam int unsigned ADJ_DONE_BIT      = 3;
  localparam int unsigned STS_MEAS_VALID    = 0; // encoder status word
  localparam int unsigned CW_PROBE_RISE_BIT = 0; // encoder control word
  localparam int unsigned CW_PROBE_FALL_BIT = 1;
  localparam int unsigned CW_PROBE_SRC_LSB  = 2;

  // ----------------------------------------------------------------
  // reset values and bus codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_ASSIGN     = 2'h1;
  localparam logic [31:0] RST_UNITS_REV  = 32'h0000_2710;
  localparam logic [31:0] RST_MOTOR_REVS = 32'h0000_0001;
  localparam logic [31:0] RST_LOAD_REVS  = 32'h0000_0001;
  localparam logic [31:0] RST_LIN_10MM   = 32'h0000_2710;
  localparam logic [31:0] RST_ENC_CFG    = 32'h010B_0800;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [1:0]  HRESP_OKAY     = 2'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;    // encoder evaluation delivers good values
    logic [31:0] raw;      // cyclic position, increments
    logic [31:0] captured; // probe captured position, increments
    logic [15:0] status;   // encoder status word
  } pac_enc_in_t;

  typedef struct packed {
    logic        corr_act; // correction activate, rising edge acts
    logic [31:0] corr_val; // signed correction, length units
    logic        set_req;  // hold position at setting value
    logic [31:0] set_val;  // position setting value
    logic [31:0] offset;   // position offset
  } pac_ch_in_t;

  typedef struct packed {
    logic [1:0]        assign_sel;
    logic              linear;
    logic [31:0]       units_rev;
    logic [31:0]       motor_revs;
    logic [31:0]       load_revs;
    logic [31:0]       lin_10mm;
    logic [2:0][31:0]  enc_cfg;
    logic [3:0][3:0]   probe_cfg;
    logic [3:0]        adj_start;
    logic [3:0]        adj_done;
    logic [3:0][31:0]  adj_off;
    logic [2:0]        seen;
    logic [2:0][31:0]  prev_raw;
    logic [2:0][31:0]  inc_acc;
    logic [2:0][31:0]  base;
    logic [3:0][31:0]  pos;
    logic [3:0][31:0]  vel;
    logic [3:0][31:0]  meas;
    logic [3:0]        corr_prev;
    logic [2:0][15:0]  ctrl_out;
    logic [3:0]        ref_conn;
    logic              a_wr;
    logic              a_map;
    logic [7:0]        a_addr;
    logic [31:0]       rdata;
  } pac_state_t;

  // register block hit: 16-byte aligned group of cnt words
  function automatic logic pac_hit(input logic [7:0] a, input logic [7:0] base,
                                   input int unsigned cnt);
    return (a[7:4] == base[7:4]) && (a[1:0] == 2'h0) && (32'(a[3:2]) < cnt);
  endfunction

endpackage

// >>> test/pac_enc_model.sv
// Purpose: behavioural encoder evaluations feeding the conditioning block
// Assumes: one position step per clock per encoder while live
// Notes:   a dropped encoder shows the inverse of its last count
`timescale 1ns/1ps

module pac_enc_model (
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // bench control
  input  wire logic [2:0]                  live,
  input  wire logic [2:0][31:0]            step,
  input  wire logic [2:0]                  meas_ok,
  // encoder interfaces
  output pac_pkg::pac_enc_in_t [2:0]       enc
);
  logic [2:0][31:0] raw_q;

  // increment counters, reset at boot
  always_ff @(posedge hclk or negedge hresetn)
  begin
    for (int e = 0; e < 3; e++)
    begin
      if (!hresetn)
        raw_q[e] <= '0;
      else if (live[e])
        raw_q[e] <= raw_q[e] + step[e];
    end
  end

  // valid flag and released count
  always_comb
  begin
    for (int e = 0; e < 3; e++)
    begin
      enc[e].valid    = live[e];
      enc[e].raw      = live[e] ? raw_q[e] : ~raw_q[e];
      enc[e].captured = ~raw_q[e];
      enc[e].status   = 16'h0000;
      enc[e].status[pac_pkg::STS_MEAS_VALID] = meas_ok[e];
    end
  end
endmodule // pac_enc_model

// >>> test/position_actual_value_conditioning_test.sv
// Purpose: self-checking bench for position conditioning
// Assumes: zero wait state slave, reset encoder scaling
// Notes:   random values from a fixed-seed lfsr
`timescale 1ns/1ps

module position_actual_value_conditioning_test;
  logic                       hclk, hresetn, hsel, hwrite, hready, hreadyout, bpa;
  logic [1:0]                 htrans, hresp;
  logic [2:0]                 hsize, live, mok;
  logic [31:0]                haddr, hwdata, hrdata, r, v, seed, pc;
  logic [2:0][31:0]           step;
  logic [2:0][15:0]           cw;
  logic [3:0][31:0]           pos, vel, meas;
  logic [3:0]                 refc;
  pac_pkg::pac_enc_in_t [2:0] enc;
  pac_pkg::pac_ch_in_t [3:0]  ch;
  int                         errors, samples_checked;

  assign hready = hreadyout;
  pac_conditioning dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enc_in(enc),
    .encoder_control_out(cw), .ch_in(ch), .basic_positioner_active(bpa),
    .position_actual_out(pos), .velocity_actual_out(vel),
    .probe_measured_value(meas), .reference_point_connect(refc));
  pac_enc_model enc_side (.hclk(hclk), .hresetn(hresetn), .live(live), .step(step),
    .meas_ok(mok), .enc(enc));

  always #5 hclk = ~hclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // increments to length units at reset scaling
  function automatic logic [31:0] lu(input logic [31:0] inc);
    logic [63:0] den;
    den = 64'(pac_pkg::RST_ENC_CFG[15:0]) << pac_pkg::RST_ENC_CFG[20:16];
    return 32'((64'(inc) * 64'(pac_pkg::RST_UNITS_REV)) / den);
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  // one ahb-lite single transfer, read data left in r
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= pac_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    r = hrdata;
    if (n >= 50)
    begin
      errors++;
      close_out();
    end
    chk("hresp", 32'(pac_pkg::HRESP_OKAY), 32'(hresp));
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge hclk);
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {hclk, hresetn, hsel, hwrite, bpa, htrans, hsize, live, mok} = '0;
    {haddr, hwdata, step, ch, errors, samples_checked} = '0;
    seed = 32'h0001_0580;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    hsize   <= 3'h2;
    // reset map and refused places
    bus(1'b0, 32'(pac_pkg::OFF_CONFIG), 32'h0);
    chk("config", 32'(pac_pkg::RST_ASSIGN), r);
    bus(1'b0, 32'(pac_pkg::OFF_UNITS_REV), 32'h0);
    chk("units_rev", pac_pkg::RST_UNITS_REV, r);
    bus(1'b0, 32'(pac_pkg::OFF_ENC_CFG), 32'h0);
    chk("enc_cfg", pac_pkg::RST_ENC_CFG, r);
    bus(1'b1, 32'h0000_0100, 32'h0000_0002);
    bus(1'b0, 32'h0000_0100, 32'h0);
    chk("unmapped", 32'h0, r);
    bus(1'b0, 32'(pac_pkg::OFF_CONFIG), 32'h0);
    chk("config kept", 32'(pac_pkg::RST_ASSIGN), r);
    $display("test map done");
    // motion on encoder one with an offset on its channel
    seed = lfsr(seed);
    ch[1].offset <= seed;
    live <= 3'h7;
    repeat (3) @(posedge hclk);
    step[0] <= 32'h0008_0000;
    repeat (6) @(posedge hclk);
    chk("velocity", lu(32'h0008_0000), vel[1]);
    repeat (2) @(posedge hclk);
    step[0] <= '0;
    repeat (4) @(posedge hclk);
    chk("pos1", lu(32'h0040_0000) + seed, pos[1]);
    chk("pos0", lu(32'h0040_0000) + seed, pos[0]);
    $display("test motion done");
    // hold at setting value while encoder moves
    v = lfsr(seed);
    ch[1].set_val <= v;
    ch[1].set_req <= 1'b1;
    step[0] <= 32'h0010_0000;
    repeat (6) @(posedge hclk);
    chk("hold", v, pos[1]);
    step[0] <= '0;
    ch[1].set_req <= 1'b0;
    // correction edge on encoder two, then reassign
    seed = lfsr(v);
    ch[2].corr_val <= seed;
    @(posedge hclk);
    ch[2].corr_act <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("corr", seed, pos[2]);
    bus(1'b1, 32'(pac_pkg::OFF_CONFIG), 32'h0000_0002);
    repeat (3) @(posedge hclk);
    chk("pos0 enc2", seed, pos[0]);
    // correction edge on channel one while encoder two holds position control
    r = pos[1];
    ch[1].corr_val <= v;
    ch[1].corr_act <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("corr1", r + v, pos[1]);
    $display("test correction done");
    // absolute adjustment on channel three
    v = lfsr(seed);
    bus(1'b1, 32'(pac_pkg::OFF_ADJ_OFFSET) + 32'hC, v);
    bus(1'b1, 32'(pac_pkg::OFF_ADJ_CTRL) + 32'hC, 32'h0000_0004);
    repeat (2) @(posedge hclk);
    bus(1'b0, 32'(pac_pkg::OFF_ADJ_CTRL) + 32'hC, 32'h0);
    chk("adj done", 32'h1, 32'(r[pac_pkg::ADJ_DONE_BIT]));
    chk("adj pos", v, pos[3]);
    // reference source only during basic positioning
    bpa <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("ref on", 32'h1, 32'(refc));
    bpa <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("ref off", 32'h0, 32'(refc));
    $display("test adjust done");
    // probe: suppressed on the control channel, passed on channel three
    pc = (32'h1 << pac_pkg::PROBE_EN_BIT) | (32'h2 << pac_pkg::PROBE_SRC_LSB)
         | (32'h1 << pac_pkg::PROBE_EDGE_BIT);
    bus(1'b1, 32'(pac_pkg::OFF_PROBE_CFG) + 32'hC, pc);
    bus(1'b1, 32'(pac_pkg::OFF_PROBE_CFG) + 32'h8, pc);
    repeat (2) @(posedge hclk);
    pc = (32'h1 << pac_pkg::CW_PROBE_FALL_BIT) | (32'h2 << pac_pkg::CW_PROBE_SRC_LSB);
    chk("cw3", pc, 32'(cw[2]));
    chk("cw2 gated", 32'h0, 32'(cw[1]));
    chk("meas idle", 32'h0, meas[3]);
    mok <= 3'h4;
    repeat (2) @(posedge hclk);
    // capture one increment behind rounds to zero units: value is the position
    chk("meas", v, meas[3]);
    $display("test probe done");
    close_out();
  end
endmodule // position_actual_value_conditioning_test
